/* File: design/iam_pkg.sv */
// Shared constants, types and decode functions for the access control entry matcher.
// Assumes a single clock domain; all header fields and settings arrive as plain levels.
`default_nettype none

package iam_pkg;

    localparam int unsigned BYTE_W = 8;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned FRAG_OFF_W = 13;

    // Well-known protocol numbers used by the shortcut protocol settings
    localparam logic [7:0] PROTO_ICMP4 = 8'h01;
    localparam logic [7:0] PROTO_ICMP6 = 8'h3A;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [7:0] PROTO_TCP = 8'h06;

    // Index of each yes/no/any criterion in the checker array
    localparam int unsigned NUM_FLAGS = 4;
    localparam int unsigned FLAG_TTL = 0;
    localparam int unsigned FLAG_FRAG = 1;
    localparam int unsigned FLAG_OPT = 2;
    localparam int unsigned FLAG_HOP = 3;

    // Values after reset and result timing
    localparam logic RST_VALID = 1'b0;
    localparam logic RST_HIT = 1'b0;
    localparam logic [2:0] RST_L4_EN = 3'h0;
    localparam logic RST_SYNC = 1'b0;
    localparam int unsigned RESULT_LATENCY = 1;

    typedef enum logic [1:0] {
        ET_ANY = 2'h0,
        ET_IPV4 = 2'h1,
        ET_IPV6 = 2'h2
    } iam_frame_type_t;

    typedef enum logic [2:0] {
        PS_ANY = 3'h0,
        PS_SPECIFIC = 3'h1,
        PS_ICMP = 3'h2,
        PS_UDP = 3'h3,
        PS_TCP = 3'h4
    } iam_proto_sel_t;

    // CLEAR: flag must be false; SET: flag must be true
    typedef enum logic [1:0] {
        TS_ANY = 2'h0,
        TS_CLEAR = 2'h1,
        TS_SET = 2'h2
    } iam_tern_t;

    typedef enum logic [1:0] {
        AM_ANY = 2'h0,
        AM_HOST = 2'h1,
        AM_NETWORK = 2'h2
    } iam_addr_mode_t;

    typedef enum logic {
        SS_ANY = 1'b0,
        SS_SPECIFIC = 1'b1
    } iam_src6_sel_t;

    // Protocol or next-header check shared by both address families
    function automatic logic iam_proto_match(input iam_proto_sel_t sel, input logic [7:0] field,
                                             input logic [7:0] value, input logic [7:0] icmp_num);
        logic ok;
        ok = 1'b0;
        case (sel)
            PS_ANY: ok = 1'b1;
            PS_SPECIFIC: ok = (field == value);
            PS_ICMP: ok = (field == icmp_num);
            PS_UDP: ok = (field == PROTO_UDP);
            PS_TCP: ok = (field == PROTO_TCP);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : iam_proto_match

    // Which layer-4 criteria groups a protocol setting opens: {icmp, udp, tcp}
    function automatic logic [2:0] iam_l4_enable(input iam_proto_sel_t sel);
        logic [2:0] en;
        en = 3'h0;
        case (sel)
            PS_ICMP: en = 3'h4;
            PS_UDP: en = 3'h2;
            PS_TCP: en = 3'h1;
            default: en = 3'h0;
        endcase
        return en;
    endfunction : iam_l4_enable

endpackage : iam_pkg

`default_nettype wire

/* File: design/iam_flag_check.sv */
// Three-way criterion on one header flag: don't-care, must be clear, must be set.
// Purely combinational; the caller registers the result.
`default_nettype none

module iam_flag_check
    import iam_pkg::*;
(
    input wire iam_pkg::iam_tern_t sel_i,
    input wire logic flag_i,
    output logic ok_o
);

    import iam_pkg::*;

    always_comb begin
        case (sel_i)
            TS_ANY: ok_o = 1'b1;
            TS_CLEAR: ok_o = !flag_i;
            TS_SET: ok_o = flag_i;
            default: ok_o = 1'b0;
        endcase
    end

endmodule : iam_flag_check

`default_nettype wire

/* File: design/iam_addr_check.sv */
// Address criterion: don't-care, exact host, or network under a mask.
// Purely combinational; a zero mask bit makes that address bit don't-care.
`default_nettype none

module iam_addr_check
    import iam_pkg::*;
(
    input wire iam_pkg::iam_addr_mode_t mode_i,
    input wire logic [iam_pkg::ADDR_W-1:0] frame_addr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_addr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_mask_i,
    output logic ok_o
);

    import iam_pkg::*;

    always_comb begin
        case (mode_i)
            AM_ANY: ok_o = 1'b1;
            AM_HOST: ok_o = (frame_addr_i == cfg_addr_i);
            AM_NETWORK: ok_o = ((frame_addr_i & cfg_mask_i) == (cfg_addr_i & cfg_mask_i));
            default: ok_o = 1'b0;
        endcase
    end

endmodule : iam_addr_check

`default_nettype wire

/* File: design/iam_matcher.sv */
// Match logic for one access control entry: IPv4 and IPv6 header criteria to a hit flag.
// Assumes header fields come from the ingress parser on sys_clk_i, qualified by frame_valid_i,
// and that the entry settings are held steady by management logic on the same clock.
//
// How it works
// RL1: IPv4 criteria apply only when the entry's frame type selection is IPv4.
// RL2: The IPv4 protocol setting is any, specific, ICMP, UDP or TCP, the last three opening their further criteria.
// RL3: With the specific protocol setting the frame's protocol byte must equal the configured byte.
// RL4: The time-to-live setting zero requires TTL of zero, non-zero requires TTL above zero, any ignores it.
// RL5: A frame is fragmented when more-fragments is set or the offset is above zero; no, yes and any act on that.
// RL6: The options setting no rejects frames with options, yes requires them, any ignores them.
// RL7: The IPv4 source setting is any, host equality, or network equality under the source mask.
// RL8: The IPv4 destination setting is any, host equality, or network equality under the destination mask.
// RL9: The IPv6 next header setting is any, specific, ICMP, UDP or TCP, the last three opening their further criteria.
// RL10: With the specific next header setting the frame's next header byte must equal the configured byte.
// RL11: The IPv6 source setting is any or specific, the latter comparing against an address and mask.
// RL12: The IPv6 source comparison covers only the low 32 address bits, with 32-bit address and mask.
// RL13: A zero mask bit is don't-care; the masked frame bits must equal the configured address ANDed with the mask.
// RL14: The hop limit setting zero requires a hop limit of zero, non-zero requires one above zero, any ignores it.
// RL15: A hit is reported only when every criterion not set to don't-care holds for the same frame.
`default_nettype none

module iam_matcher
    import iam_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Header fields from the ingress parser
    input wire logic frame_valid_i,
    input wire logic frame_is_ipv4_i,
    input wire logic frame_is_ipv6_i,
    input wire logic [iam_pkg::BYTE_W-1:0] ip_proto_i,
    input wire logic [iam_pkg::BYTE_W-1:0] ip_ttl_i,
    input wire logic ip_more_frag_i,
    input wire logic [iam_pkg::FRAG_OFF_W-1:0] ip_frag_offset_i,
    input wire logic ip_options_i,
    input wire logic [iam_pkg::ADDR_W-1:0] ip_src_addr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] ip_dst_addr_i,
    input wire logic [iam_pkg::BYTE_W-1:0] ip6_next_hdr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] ip6_src_low_i,
    input wire logic [iam_pkg::BYTE_W-1:0] ip6_hop_limit_i,
    // Entry settings
    input wire iam_pkg::iam_frame_type_t access_control_entry_type_i,
    input wire iam_pkg::iam_proto_sel_t cfg_proto_sel_i,
    input wire logic [iam_pkg::BYTE_W-1:0] cfg_proto_value_i,
    input wire iam_pkg::iam_tern_t cfg_ttl_sel_i,
    input wire iam_pkg::iam_tern_t cfg_frag_sel_i,
    input wire iam_pkg::iam_tern_t cfg_options_sel_i,
    input wire iam_pkg::iam_addr_mode_t source_ip_criterion_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_src_addr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_src_mask_i,
    input wire iam_pkg::iam_addr_mode_t destination_ip_criterion_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_dst_addr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_dst_mask_i,
    input wire iam_pkg::iam_proto_sel_t cfg_next_hdr_sel_i,
    input wire logic [iam_pkg::BYTE_W-1:0] cfg_next_hdr_value_i,
    input wire iam_pkg::iam_src6_sel_t cfg_ip6_src_sel_i,
    input wire logic [iam_pkg::ADDR_W-1:0] cfg_ip6_src_addr_i,
    input wire logic [iam_pkg::ADDR_W-1:0] source_ipv6_low_mask_i,
    input wire iam_pkg::iam_tern_t cfg_hop_sel_i,
    // Result
    output logic result_valid_o,
    output logic hit_o,
    output logic icmp_crit_en_o,
    output logic udp_crit_en_o,
    output logic tcp_crit_en_o
);

    import iam_pkg::*;

    // Reset synchroniser: asserts at once, releases after two edges
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= RST_SYNC;
            rst_sync_n <= RST_SYNC;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Yes/no/any criteria, one checker each
    logic [NUM_FLAGS-1:0] flag_val;
    logic [NUM_FLAGS-1:0] flag_ok;
    iam_tern_t flag_sel [NUM_FLAGS];

    assign flag_val[FLAG_TTL] = (ip_ttl_i != '0); // RL4
    assign flag_val[FLAG_FRAG] = ip_more_frag_i || (ip_frag_offset_i != '0); // RL5
    assign flag_val[FLAG_OPT] = ip_options_i; // RL6
    assign flag_val[FLAG_HOP] = (ip6_hop_limit_i != '0); // RL14
    assign flag_sel[FLAG_TTL] = cfg_ttl_sel_i;
    assign flag_sel[FLAG_FRAG] = cfg_frag_sel_i;
    assign flag_sel[FLAG_OPT] = cfg_options_sel_i;
    assign flag_sel[FLAG_HOP] = cfg_hop_sel_i;

    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
            iam_flag_check u_flag (
                .sel_i(flag_sel[g]),
                .flag_i(flag_val[g]),
                .ok_o(flag_ok[g])
            );
        end
    endgenerate

    // Address criteria
    logic src4_ok;
    logic dst4_ok;
    logic src6_ok;
    iam_addr_mode_t src6_mode;

    assign src6_mode = (cfg_ip6_src_sel_i == SS_SPECIFIC) ? AM_NETWORK : AM_ANY; // RL11

    iam_addr_check u_src4 (
        .mode_i(source_ip_criterion_i), // RL7
        .frame_addr_i(ip_src_addr_i),
        .cfg_addr_i(cfg_src_addr_i),
        .cfg_mask_i(cfg_src_mask_i),
        .ok_o(src4_ok)
    );

    iam_addr_check u_dst4 (
        .mode_i(destination_ip_criterion_i), // RL8
        .frame_addr_i(ip_dst_addr_i),
        .cfg_addr_i(cfg_dst_addr_i),
        .cfg_mask_i(cfg_dst_mask_i),
        .ok_o(dst4_ok)
    );

    // Low 32 bits only, masked compare
    iam_addr_check u_src6 (
        .mode_i(src6_mode), // RL12 RL13
        .frame_addr_i(ip6_src_low_i),
        .cfg_addr_i(cfg_ip6_src_addr_i),
        .cfg_mask_i(source_ipv6_low_mask_i),
        .ok_o(src6_ok)
    );

    // Per-family verdicts and result register
    logic v4_ok;
    logic v6_ok;
    logic next_valid;
    logic next_hit;
    logic [2:0] next_l4_en;
    logic [2:0] l4_en;

    always_comb begin
        v4_ok = frame_is_ipv4_i
              && iam_proto_match(cfg_proto_sel_i, ip_proto_i, cfg_proto_value_i, PROTO_ICMP4) // RL2 RL3
              && flag_ok[FLAG_TTL] && flag_ok[FLAG_FRAG] && flag_ok[FLAG_OPT]
              && src4_ok && dst4_ok; // RL15
        v6_ok = frame_is_ipv6_i
              && iam_proto_match(cfg_next_hdr_sel_i, ip6_next_hdr_i, cfg_next_hdr_value_i, PROTO_ICMP6) // RL9 RL10
              && src6_ok && flag_ok[FLAG_HOP]; // RL15
        next_valid = frame_valid_i;
        next_hit = 1'b0;
        next_l4_en = 3'h0;
        if (frame_valid_i) begin
            case (access_control_entry_type_i)
                ET_ANY: begin
                    next_hit = 1'b1;
                end
                ET_IPV4: begin
                    next_hit = v4_ok; // RL1
                    next_l4_en = iam_l4_enable(cfg_proto_sel_i); // RL2
                end
                ET_IPV6: begin
                    next_hit = v6_ok;
                    next_l4_en = iam_l4_enable(cfg_next_hdr_sel_i); // RL9
                end
                default: begin
                    next_hit = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result_valid_o <= RST_VALID;
            hit_o <= RST_HIT;
            l4_en <= RST_L4_EN;
        end else begin
            result_valid_o <= next_valid;
            hit_o <= next_hit;
            l4_en <= next_l4_en;
        end
    end

    assign icmp_crit_en_o = l4_en[2];
    assign udp_crit_en_o = l4_en[1];
    assign tcp_crit_en_o = l4_en[0];

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_sync_n);

    logic v4_in;
    logic v6_in;
    assign v4_in = frame_valid_i && (access_control_entry_type_i == ET_IPV4) && frame_is_ipv4_i;
    assign v6_in = frame_valid_i && (access_control_entry_type_i == ET_IPV6) && frame_is_ipv6_i;

    a_result_timing: assert property (frame_valid_i |=> result_valid_o ##1 (result_valid_o == $past(frame_valid_i)))
        else $error("result strobe does not follow the frame strobe");
    a_hit_needs_valid: assert property (hit_o |-> result_valid_o && $past(frame_valid_i)) // RL15
        else $error("hit without a frame");
    a_type_gate: assert property (frame_valid_i && access_control_entry_type_i == ET_IPV4 && !frame_is_ipv4_i
                                  |=> !hit_o) // RL1
        else $error("IPv4 entry hit a non-IPv4 frame");
    a_proto_spec: assert property (v4_in && cfg_proto_sel_i == PS_SPECIFIC && ip_proto_i != cfg_proto_value_i
                                   |=> !hit_o) // RL3
        else $error("specific protocol hit on a different protocol");
    a_proto_tcp: assert property (v4_in && cfg_proto_sel_i == PS_TCP
                                  |=> tcp_crit_en_o && !udp_crit_en_o && (hit_o -> $past(ip_proto_i) == PROTO_TCP)) // RL2
        else $error("TCP protocol setting mishandled");
    a_ttl_zero: assert property (v4_in && cfg_ttl_sel_i == TS_CLEAR && ip_ttl_i != '0 |=> !hit_o) // RL4
        else $error("TTL zero setting hit a live frame");
    a_frag_no: assert property (v4_in && cfg_frag_sel_i == TS_CLEAR && (ip_more_frag_i || ip_frag_offset_i != '0)
                                |=> !hit_o) // RL5
        else $error("fragment setting no hit a fragment");
    a_opt_yes: assert property (v4_in && cfg_options_sel_i == TS_SET && !ip_options_i |=> !hit_o) // RL6
        else $error("options setting yes hit a frame without options");
    a_src_host: assert property (v4_in && source_ip_criterion_i == AM_HOST && ip_src_addr_i != cfg_src_addr_i
                                 |=> !hit_o) // RL7
        else $error("source host hit a different address");
    a_dst_net: assert property (v4_in && destination_ip_criterion_i == AM_NETWORK
                                && ((ip_dst_addr_i ^ cfg_dst_addr_i) & cfg_dst_mask_i) != '0 |=> !hit_o) // RL8
        else $error("destination network hit outside the network");
    a_nh_udp: assert property (v6_in && cfg_next_hdr_sel_i == PS_UDP && ip6_next_hdr_i != PROTO_UDP
                               |=> !hit_o && udp_crit_en_o) // RL9
        else $error("UDP next header setting mishandled");
    a_nh_spec: assert property (v6_in && cfg_next_hdr_sel_i == PS_SPECIFIC && ip6_next_hdr_i != cfg_next_hdr_value_i
                                |=> !hit_o) // RL10
        else $error("specific next header hit on a different value");
    a_src6_mask: assert property (v6_in && cfg_ip6_src_sel_i == SS_SPECIFIC
                                  && ((ip6_src_low_i ^ cfg_ip6_src_addr_i) & source_ipv6_low_mask_i) != '0
                                  |=> !hit_o) // RL11 RL12 RL13
        else $error("IPv6 source hit outside the mask");
    a_hop_zero: assert property (v6_in && cfg_hop_sel_i == TS_CLEAR && ip6_hop_limit_i != '0 |=> !hit_o) // RL14
        else $error("hop limit zero setting hit a live frame");
    a_all_dontcare: assert property (v4_in && cfg_proto_sel_i == PS_ANY && cfg_ttl_sel_i == TS_ANY
                                     && cfg_frag_sel_i == TS_ANY && cfg_options_sel_i == TS_ANY
                                     && source_ip_criterion_i == AM_ANY && destination_ip_criterion_i == AM_ANY
                                     |=> hit_o) // RL15
        else $error("all don't-care entry missed an IPv4 frame");

    c_hit_v4: cover property (v4_in ##1 hit_o);
    c_hit_v6: cover property (v6_in && cfg_ip6_src_sel_i == SS_SPECIFIC ##1 hit_o);
    c_miss: cover property (frame_valid_i ##1 result_valid_o && !hit_o);
    c_back_to_back: cover property (frame_valid_i ##1 frame_valid_i ##1 result_valid_o);

endmodule : iam_matcher

`default_nettype wire

/* File: sim/iam_parser_model.sv */
// Ingress parser model: presents one header per call and scrambles the fields between frames.
// Assumes every task is entered just after a rising edge of sys_clk_i.
`default_nettype none

module iam_parser_model (
    input wire logic sys_clk_i,
    output logic frame_valid_o,
    output logic [144:0] hdr_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        frame_valid_o = 1'b0;
        hdr_o = '0;
    end

    // Valid stays up between calls, so back-to-back frames need no gap
    task automatic send(input logic [144:0] h);
        frame_valid_o = 1'b1;
        hdr_o = h;
        @(posedge sys_clk_i);
        #1;
    endtask : send

    // Fields are not held outside a frame: invert them so stale values never look valid
    task automatic idle();
        frame_valid_o = 1'b0;
        hdr_o = ~hdr_o;
        @(posedge sys_clk_i);
        #1;
    endtask : idle

endmodule : iam_parser_model

`default_nettype wire

/* File: sim/tb_iam_matcher.sv */
// Self-checking bench for the entry matcher: directed and random headers, expected results on a queue.
// Assumes the parser model of iam_parser_model.sv and a 100 MHz clock.
`default_nettype none

module tb_iam_matcher;
    timeunit 1ns;
    timeprecision 100ps;
    import iam_pkg::*;

    typedef struct packed {
        logic v4;
        logic v6;
        logic [7:0] proto;
        logic [7:0] ttl;
        logic mf;
        logic [12:0] off;
        logic opt;
        logic [31:0] src;
        logic [31:0] dst;
        logic [7:0] nh;
        logic [31:0] s6;
        logic [7:0] hop;
    } iam_hdr_t;
    typedef struct packed {
        logic [31:0] due;
        logic [3:0] res;
    } iam_note_t;

    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic frame_valid_i;
    iam_hdr_t hdr;
    iam_hdr_t h0 = '0;
    logic result_valid_o, hit_o, icmp_crit_en_o, udp_crit_en_o, tcp_crit_en_o;
    iam_frame_type_t access_control_entry_type_i = ET_ANY;
    iam_proto_sel_t cfg_proto_sel_i = PS_ANY, cfg_next_hdr_sel_i = PS_ANY;
    iam_tern_t cfg_ttl_sel_i = TS_ANY, cfg_frag_sel_i = TS_ANY, cfg_options_sel_i = TS_ANY, cfg_hop_sel_i = TS_ANY;
    iam_addr_mode_t source_ip_criterion_i = AM_ANY, destination_ip_criterion_i = AM_ANY;
    iam_src6_sel_t cfg_ip6_src_sel_i = SS_ANY;
    logic [7:0] cfg_proto_value_i = '0, cfg_next_hdr_value_i = '0;
    logic [31:0] cfg_src_addr_i = '0, cfg_src_mask_i = '0, cfg_dst_addr_i = '0, cfg_dst_mask_i = '0;
    logic [31:0] cfg_ip6_src_addr_i = '0, source_ipv6_low_mask_i = '0;
    int seed = 22760;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] cyc = '0;
    iam_note_t notes[$];
    iam_note_t got;

    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;

    iam_matcher dut (
        .sys_clk_i, .rst_n_i, .frame_valid_i,
        .frame_is_ipv4_i(hdr.v4), .frame_is_ipv6_i(hdr.v6), .ip_proto_i(hdr.proto), .ip_ttl_i(hdr.ttl),
        .ip_more_frag_i(hdr.mf), .ip_frag_offset_i(hdr.off), .ip_options_i(hdr.opt), .ip_src_addr_i(hdr.src),
        .ip_dst_addr_i(hdr.dst), .ip6_next_hdr_i(hdr.nh), .ip6_src_low_i(hdr.s6), .ip6_hop_limit_i(hdr.hop),
        .access_control_entry_type_i, .cfg_proto_sel_i, .cfg_proto_value_i, .cfg_ttl_sel_i, .cfg_frag_sel_i,
        .cfg_options_sel_i, .source_ip_criterion_i, .cfg_src_addr_i, .cfg_src_mask_i, .destination_ip_criterion_i,
        .cfg_dst_addr_i, .cfg_dst_mask_i, .cfg_next_hdr_sel_i, .cfg_next_hdr_value_i, .cfg_ip6_src_sel_i,
        .cfg_ip6_src_addr_i, .source_ipv6_low_mask_i, .cfg_hop_sel_i, .result_valid_o, .hit_o, .icmp_crit_en_o,
        .udp_crit_en_o, .tcp_crit_en_o
    );
    iam_parser_model prs (.sys_clk_i, .frame_valid_o(frame_valid_i), .hdr_o(hdr));

    function automatic int rnd(input int n);
        return int'($unsigned($random(seed)) % n);
    endfunction : rnd

    function automatic logic tern(input logic [1:0] s, input logic f);
        return s == 2'h0 ? 1'b1 : s == 2'h1 ? !f : s == 2'h2 ? f : 1'b0;
    endfunction : tern

    function automatic logic adr(input logic [1:0] m, input logic [31:0] a, input logic [31:0] c,
                                 input logic [31:0] k);
        return m == 2'h0 ? 1'b1 : m == 2'h1 ? a == c : m == 2'h2 ? (a & k) == (c & k) : 1'b0;
    endfunction : adr

    function automatic logic prot(input logic [2:0] s, input logic [7:0] f, input logic [7:0] v,
                                  input logic [7:0] ic);
        return s == 3'h0 ? 1'b1 : s == 3'h1 ? f == v : s == 3'h2 ? f == ic : s == 3'h3 ? f == PROTO_UDP
            : s == 3'h4 ? f == PROTO_TCP : 1'b0;
    endfunction : prot

    // Expected {hit, icmp, udp, tcp} for a header under the current entry settings
    function automatic logic [3:0] expect_of(input iam_hdr_t h);
        logic v4ok, v6ok;
        logic [2:0] sel;
        v4ok = h.v4 && prot(cfg_proto_sel_i, h.proto, cfg_proto_value_i, PROTO_ICMP4) && tern(cfg_ttl_sel_i, h.ttl != 0)
            && tern(cfg_frag_sel_i, h.mf || h.off != 0) && tern(cfg_options_sel_i, h.opt)
            && adr(source_ip_criterion_i, h.src, cfg_src_addr_i, cfg_src_mask_i)
            && adr(destination_ip_criterion_i, h.dst, cfg_dst_addr_i, cfg_dst_mask_i);
        v6ok = h.v6 && prot(cfg_next_hdr_sel_i, h.nh, cfg_next_hdr_value_i, PROTO_ICMP6)
            && (cfg_ip6_src_sel_i == SS_ANY || (h.s6 & source_ipv6_low_mask_i) ==
                (cfg_ip6_src_addr_i & source_ipv6_low_mask_i)) && tern(cfg_hop_sel_i, h.hop != 0);
        sel = access_control_entry_type_i == ET_IPV4 ? cfg_proto_sel_i
            : access_control_entry_type_i == ET_IPV6 ? cfg_next_hdr_sel_i : PS_ANY;
        return {access_control_entry_type_i == ET_ANY || (access_control_entry_type_i == ET_IPV4 && v4ok)
            || (access_control_entry_type_i == ET_IPV6 && v6ok), sel == PS_ICMP, sel == PS_UDP, sel == PS_TCP};
    endfunction : expect_of

    function automatic logic [7:0] pick8(input logic [7:0] v);
        logic [7:0] t [5] = '{v, PROTO_ICMP4, PROTO_ICMP6, PROTO_UDP, PROTO_TCP};
        return rnd(4) == 0 ? 8'(rnd(256)) : t[rnd(5)];
    endfunction : pick8

    // Zero and one are favoured to hit the greater-than-zero boundary
    function automatic logic [31:0] low_biased(input int w);
        return rnd(3) == 0 ? 32'h0 : rnd(2) == 0 ? 32'h1 : 32'(rnd(1 << w));
    endfunction : low_biased

    function automatic logic [31:0] near(input logic [31:0] c, input logic [31:0] k);
        return rnd(3) == 0 ? c : rnd(2) == 0 ? c ^ (32'($random(seed)) & ~k) : 32'($random(seed));
    endfunction : near

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (exp !== seen) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic send_frame(input iam_hdr_t h);
        iam_note_t n;
        n.due = cyc + 1;
        n.res = expect_of(h);
        notes.push_back(n);
        prs.send(h);
    endtask : send_frame

    task automatic one_frame();
        iam_hdr_t h;
        // Includes the unused type encoding, which must never hit
        access_control_entry_type_i = iam_frame_type_t'(2'(rnd(7) / 2));
        cfg_proto_sel_i = iam_proto_sel_t'(3'(rnd(6)));
        cfg_next_hdr_sel_i = iam_proto_sel_t'(3'(rnd(6)));
        cfg_ttl_sel_i = iam_tern_t'(2'(rnd(7) / 2));
        cfg_frag_sel_i = iam_tern_t'(2'(rnd(7) / 2));
        cfg_options_sel_i = iam_tern_t'(2'(rnd(7) / 2));
        cfg_hop_sel_i = iam_tern_t'(2'(rnd(7) / 2));
        source_ip_criterion_i = iam_addr_mode_t'(2'(rnd(7) / 2));
        destination_ip_criterion_i = iam_addr_mode_t'(2'(rnd(7) / 2));
        cfg_ip6_src_sel_i = iam_src6_sel_t'(1'(rnd(2)));
        cfg_proto_value_i = 8'(rnd(256));
        cfg_next_hdr_value_i = 8'(rnd(256));
        {cfg_src_addr_i, cfg_src_mask_i, cfg_dst_addr_i} = {$random(seed), $random(seed), $random(seed)};
        {cfg_dst_mask_i, cfg_ip6_src_addr_i, source_ipv6_low_mask_i} = {$random(seed), $random(seed), $random(seed)};
        h.v4 = rnd(4) == 0 ? 1'(rnd(2)) : access_control_entry_type_i == ET_IPV4;
        h.v6 = rnd(4) == 0 ? 1'(rnd(2)) : access_control_entry_type_i == ET_IPV6;
        h.proto = pick8(cfg_proto_value_i);
        h.nh = pick8(cfg_next_hdr_value_i);
        h.ttl = 8'(low_biased(8));
        h.hop = 8'(low_biased(8));
        h.off = 13'(low_biased(13));
        h.mf = 1'(rnd(2));
        h.opt = 1'(rnd(2));
        h.src = near(cfg_src_addr_i, cfg_src_mask_i);
        h.dst = near(cfg_dst_addr_i, cfg_dst_mask_i);
        h.s6 = near(cfg_ip6_src_addr_i, source_ipv6_low_mask_i);
        send_frame(h);
    endtask : one_frame

    // A frame offered while reset is held must produce no result
    task automatic mid_reset();
        prs.idle();
        prs.idle();
        rst_n_i = 1'b0;
        prs.send(h0);
        check("outputs in reset", 32'h0, {result_valid_o, hit_o, icmp_crit_en_o, udp_crit_en_o, tcp_crit_en_o});
        prs.idle();
        repeat (2) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask : mid_reset

    always @(negedge sys_clk_i) begin
        if (result_valid_o === 1'b1 && notes.size() > 0) begin
            got = notes.pop_front();
            check("result cycle", got.due, cyc);
            check("hit and enables", 32'(got.res), {hit_o, icmp_crit_en_o, udp_crit_en_o, tcp_crit_en_o});
        end else begin
            check("outputs idle", 32'h0, {result_valid_o, hit_o, icmp_crit_en_o, udp_crit_en_o, tcp_crit_en_o});
        end
    end

    initial begin
        #200000;
        err_total++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        // Bit 0 masked off: low bits 2 and 3 hit, 1 and a high-bit change miss
        access_control_entry_type_i = ET_IPV6;
        cfg_ip6_src_sel_i = SS_SPECIFIC;
        cfg_ip6_src_addr_i = 32'h0000_0003;
        source_ipv6_low_mask_i = 32'hFFFF_FFFE;
        h0.v6 = 1'b1;
        for (int i = 0; i < 4; i++) begin
            h0.s6 = i == 0 ? 32'h8000_0003 : 32'(i);
            send_frame(h0);
        end
        for (int i = 0; i < 3000; i++) begin
            if (i == 1500) mid_reset();
            if (rnd(4) == 0) prs.idle();
            else one_frame();
        end
        prs.idle();
        prs.idle();
        check("pending results", 32'h0, 32'(notes.size()));
        final_report();
    end

endmodule : tb_iam_matcher

`default_nettype wire
